// File: pkg/interrupt_unmask_map.svh
/*
  Register offsets, reset values, field positions and masks of the event
  unmask block. Assumes a 16-bit register address and 8-bit register data.
*/
`ifndef INTERRUPT_UNMASK_MAP_SVH
`define INTERRUPT_UNMASK_MAP_SVH

// Offsets
`define UNMASK_BANK_A_OFF  16'h2010
`define UNMASK_BANK_B_OFF  16'h2011
`define CLEAR_BANK_A_OFF   16'h2015
`define CLEAR_BANK_B_OFF   16'h2016

// Reset values
`define UNMASK_BANK_A_RST  8'h02
`define UNMASK_BANK_B_RST  8'h00

// Implemented bits of bank b; the rest read zero and ignore writes
`define BANK_B_USED_MASK   8'h37

// Bank a fields
`define THERMAL_SHUTDOWN_START_BIT   7
`define THERMAL_SHUTDOWN_STOP_BIT    6
`define THERMAL_WARNING_START_BIT    5
`define THERMAL_WARNING_STOP_BIT     4
`define THERMAL_FOLDBACK_START_BIT   3
`define THERMAL_FOLDBACK_STOP_BIT    2
`define MEMORY_FAILURE_BIT           1
`define SPEAKER_OVERCURRENT_BIT      0

// Bank b fields
`define INTERNAL_SPEAKER_MONITOR_BIT 5
`define INTERNAL_CLOCK_ERROR_BIT     4
`define CLOCK_RECOVERY_BIT           2
`define CLOCK_ERROR_BIT              1
`define DATA_MONITOR_ERROR_BIT       0

`endif

// File: pkg/interrupt_unmask_pkg.sv
/*
  Types shared by the event unmask block. Assumes the map header supplies
  all numeric constants.
*/
package interrupt_unmask_pkg;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [15:0] reg_addr_t;
endpackage

// File: hw/raw_sync.sv
/*
  Two-stage synchroniser for a vector of raw event conditions.
  Assumes each bit is an independent level from outside the clock domain.
*/
`timescale 1ns/10ps
module raw_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  if (WIDTH < 1) begin : g_bad_width
    $error("raw_sync needs WIDTH of at least 1");
  end

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule

// File: hw/event_flag_cell.sv
/*
  A bank of sticky event flags with edge detect, unmask and clear.
  Assumes raw inputs are already synchronous to clk_i.
*/
`timescale 1ns/10ps
module event_flag_cell #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] raw_i,
  input  wire logic [WIDTH-1:0] unmask_i,
  input  wire logic [WIDTH-1:0] clear_i,
  output logic      [WIDTH-1:0] edge_o,
  output logic      [WIDTH-1:0] state_o,
  output logic      [WIDTH-1:0] event_o
);
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] prev_d;
  logic [WIDTH-1:0] state_q;
  logic [WIDTH-1:0] state_d;
  logic [WIDTH-1:0] event_q;
  logic [WIDTH-1:0] event_d;
  logic [WIDTH-1:0] rise;

  if (WIDTH < 1) begin : g_bad_width
    $error("event_flag_cell needs WIDTH of at least 1");
  end

  always_comb begin
    rise    = raw_i & ~prev_q;
    prev_d  = raw_i;
    // Set beats clear so an edge in the clearing cycle is kept
    state_d = rise | (state_q & ~clear_i);
    // A masked flag is held low whatever the history
    event_d = unmask_i & (rise | (event_q & ~clear_i));
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_q  <= '0;
      state_q <= '0;
      event_q <= '0;
    end else begin
      prev_q  <= prev_d;
      state_q <= state_d;
      event_q <= event_d;
    end
  end

  assign edge_o  = rise;
  assign state_o = state_q;
  assign event_o = event_q;
endmodule

// File: hw/interrupt_unmask_control.sv
/*
  Event unmask control: two unmask banks, two write-only clear banks,
  sticky event flags and a one-cycle interrupt pulse.
  Assumes a synchronous register port from the control interface and raw
  event conditions that arrive asynchronously.
*/
// Summary of operation
// - Bank a bit 7 unmasks thermal shutdown start; masked flag stays low.
// - Bank a bit 6 unmasks thermal shutdown stop; set on raw rising edge.
// - Bank a bit 5 unmasks thermal warning start; set on raw rising edge.
// - Bank a bit 4 unmasks thermal warning stop; set on raw rising edge.
// - Bank a bit 3 unmasks thermal foldback start; set on raw rising edge.
// - Bank a bit 2 unmasks thermal foldback stop; set on raw rising edge.
// - Bank a bit 1 unmasks memory failure, resets to one.
// - Bank a bit 0 unmasks speaker overcurrent; set on raw rising edge.
// - Bank b bit 5 unmasks internal speaker monitor error.
// - Bank b bit 4 unmasks internal clock error.
// - Bank b bit 2 unmasks clock recovery.
// - Bank b bit 1 unmasks clock error.
// - Bank b bit 0 unmasks data monitor error.
// - With interrupt enabled, any flag rising from 0 to 1 raises an interrupt.
// - Flags stay set until a one is written to their clear bit or a zero to their unmask bit.
`timescale 1ns/10ps
`include "interrupt_unmask_map.svh"
module interrupt_unmask_control #(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic      [7:0]        reg_rdata_o,
  input  wire logic [7:0]        raw_a_i,
  input  wire logic [7:0]        raw_b_i,
  input  wire logic              irq_en_i,
  output logic      [7:0]        event_a_o,
  output logic      [7:0]        event_b_o,
  output logic                   irq_o
);
  interrupt_unmask_pkg::reg_byte_t unmask_a_q;
  interrupt_unmask_pkg::reg_byte_t unmask_a_d;
  interrupt_unmask_pkg::reg_byte_t unmask_b_q;
  interrupt_unmask_pkg::reg_byte_t unmask_b_d;
  interrupt_unmask_pkg::reg_byte_t rdata_q;
  interrupt_unmask_pkg::reg_byte_t rdata_d;
  interrupt_unmask_pkg::reg_byte_t clear_a;
  interrupt_unmask_pkg::reg_byte_t clear_b;
  interrupt_unmask_pkg::reg_addr_t addr;
  logic [15:0] event_prev_q;
  logic [15:0] event_prev_d;
  logic        irq_q;
  logic        irq_d;
  logic [7:0]  raw_a_sync;
  logic [7:0]  raw_b_sync;
  logic [7:0]  edge_a;
  logic [7:0]  edge_b;
  logic [7:0]  event_a;
  logic [7:0]  event_b;
  logic        hit_a;
  logic        hit_b;
  logic        hit_clr_a;
  logic        hit_clr_b;
  logic [7:0]  hold_a;
  logic [7:0]  hold_b;
  logic [7:0]  wipe_a;
  logic [7:0]  wipe_b;

  if (ADDR_W < 14 || ADDR_W > 16) begin : g_bad_addr
    $error("interrupt_unmask_control needs ADDR_W between 14 and 16");
  end

  assign addr      = interrupt_unmask_pkg::reg_addr_t'(reg_addr_i);
  assign hit_a     = (addr == `UNMASK_BANK_A_OFF);
  assign hit_b     = (addr == `UNMASK_BANK_B_OFF);
  assign hit_clr_a = (addr == `CLEAR_BANK_A_OFF);
  assign hit_clr_b = (addr == `CLEAR_BANK_B_OFF);

  // Clear banks are write-only strobes, nothing stored
  always_comb begin
    clear_a = (reg_wr_i && hit_clr_a) ? reg_wdata_i : 8'h00;
    clear_b = (reg_wr_i && hit_clr_b) ? reg_wdata_i : 8'h00;
  end

  always_comb begin
    unmask_a_d = unmask_a_q;
    unmask_b_d = unmask_b_q;
    rdata_d    = rdata_q;
    if (reg_wr_i && hit_a) begin
      unmask_a_d = reg_wdata_i;
    end
    if (reg_wr_i && hit_b) begin
      unmask_b_d = reg_wdata_i & `BANK_B_USED_MASK;
    end
    if (reg_rd_i) begin
      if (hit_a) begin
        rdata_d = unmask_a_q;
      end else if (hit_b) begin
        rdata_d = unmask_b_q & `BANK_B_USED_MASK;
      end else begin
        // Clear banks and unmapped offsets read zero
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      unmask_a_q <= `UNMASK_BANK_A_RST;
      unmask_b_q <= `UNMASK_BANK_B_RST;
      rdata_q    <= 8'h00;
    end else begin
      unmask_a_q <= unmask_a_d;
      unmask_b_q <= unmask_b_d;
      rdata_q    <= rdata_d;
    end
  end

  raw_sync #(
    .WIDTH (8)
  ) u_sync_a (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i (raw_a_i),
    .sync_o  (raw_a_sync)
  );

  raw_sync #(
    .WIDTH (8)
  ) u_sync_b (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i (raw_b_i),
    .sync_o  (raw_b_sync)
  );

  // Bank a flags, every bit gated by its unmask bit
  event_flag_cell #(
    .WIDTH (8)
  ) u_flags_a (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .raw_i    (raw_a_sync),
    .unmask_i (unmask_a_q),
    .clear_i  (clear_a),
    .edge_o   (edge_a),
    .state_o  (),
    .event_o  (event_a)
  );

  // Reserved bank b bits never unmask, so their flags stay low
  event_flag_cell #(
    .WIDTH (8)
  ) u_flags_b (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .raw_i    (raw_b_sync),
    .unmask_i (unmask_b_q & `BANK_B_USED_MASK),
    .clear_i  (clear_b),
    .edge_o   (edge_b),
    .state_o  (),
    .event_o  (event_b)
  );

  // Pulse on a 0 to 1 flag change only, not on a flag that stays high
  always_comb begin
    event_prev_d = {event_b, event_a};
    irq_d        = irq_en_i && ((|({event_b, event_a} & ~event_prev_q)));
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      event_prev_q <= 16'h0000;
      irq_q        <= 1'b0;
    end else begin
      event_prev_q <= event_prev_d;
      irq_q        <= irq_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign event_a_o   = event_a;
  assign event_b_o   = event_b;
  assign irq_o       = irq_q;

  // Flags that must survive the next edge, and flags that a clear must drop
  assign hold_a = event_a & unmask_a_q & ~clear_a;
  assign hold_b = event_b & unmask_b_q & ~clear_b;
  // Set beats clear, so only bits without a fresh edge must fall
  assign wipe_a = clear_a & ~edge_a;
  assign wipe_b = clear_b & ~edge_b;

  a_shdn_start_gate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!unmask_a_q[7] |=> !event_a[7]) and (unmask_a_q[7] && edge_a[7] |=> event_a[7]))
    else $error("thermal shutdown start flag ignores its unmask");

  a_shdn_stop_gate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!unmask_a_q[6] |=> !event_a[6]) and (unmask_a_q[6] && edge_a[6] |=> event_a[6]))
    else $error("thermal shutdown stop flag ignores its unmask");

  a_warn_start_gate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!unmask_a_q[5] |=> !event_a[5]) and (unmask_a_q[5] && edge_a[5] |=> event_a[5]))
    else $error("thermal warning start flag ignores its unmask");

  a_warn_stop_gate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!unmask_a_q[4] |=> !event_a[4]) and (unmask_a_q[4] && edge_a[4] |=> event_a[4]))
    else $error("thermal warning stop flag ignores its unmask");

  a_fold_start_gate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!unmask_a_q[3] |=> !event_a[3]) and (unmask_a_q[3] && edge_a[3] |=> event_a[3]))
    else $error("thermal foldback start flag ignores its unmask");

  a_fold_stop_gate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!unmask_a_q[2] |=> !event_a[2]) and (unmask_a_q[2] && edge_a[2] |=> event_a[2]))
    else $error("thermal foldback stop flag ignores its unmask");

  a_memfail_gate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    ($rose(nrst_i) |-> unmask_a_q[1])
    and (unmask_a_q[1] && edge_a[1] |=> event_a[1])
    and (!unmask_a_q[1] |=> !event_a[1]))
    else $error("memory failure flag or its reset unmask is wrong");

  a_overcurrent_gate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!unmask_a_q[0] |=> !event_a[0]) and (unmask_a_q[0] && edge_a[0] |=> event_a[0]))
    else $error("speaker overcurrent flag ignores its unmask");

  a_speaker_mon_gate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!unmask_b_q[5] |=> !event_b[5]) and (unmask_b_q[5] && edge_b[5] |=> event_b[5]))
    else $error("speaker monitor error flag ignores its unmask");

  a_intclk_gate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!unmask_b_q[4] |=> !event_b[4]) and (unmask_b_q[4] && edge_b[4] |=> event_b[4]))
    else $error("internal clock error flag ignores its unmask");

  a_recover_gate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!unmask_b_q[2] |=> !event_b[2]) and (unmask_b_q[2] && edge_b[2] |=> event_b[2]))
    else $error("clock recovery flag ignores its unmask");

  a_clkerr_gate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!unmask_b_q[1] |=> !event_b[1]) and (unmask_b_q[1] && edge_b[1] |=> event_b[1]))
    else $error("clock error flag ignores its unmask");

  a_data_mon_gate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!unmask_b_q[0] |=> !event_b[0]) and (unmask_b_q[0] && edge_b[0] |=> event_b[0]))
    else $error("data monitor error flag ignores its unmask");

  a_irq_on_rise: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (irq_en_i && (|({event_b, event_a} & ~event_prev_q)) |=> irq_o)
    and (!irq_en_i |=> !irq_o))
    else $error("interrupt pulse does not follow a flag rise");

  a_flag_sticky_hold: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (event_a[3] && unmask_a_q[3] && !clear_a[3]) ##1 unmask_a_q[3] |-> event_a[3])
    else $error("flag dropped without a clear");

  a_flag_clear_write: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    reg_wr_i && hit_clr_b && reg_wdata_i[1] && !edge_b[1] |=> !event_b[1])
    else $error("clear write left the flag set");

  a_reserved_zero: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    reg_rd_i && hit_b |=> (reg_rdata_o[7:6] == 2'b00) && !reg_rdata_o[3] && !event_b[3])
    else $error("reserved bank b bit reads nonzero");

  a_irq_no_rise: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !(|({event_b, event_a} & ~event_prev_q)) |=> !irq_o)
    else $error("interrupt pulse without a flag rise");

  a_sticky_bank_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (|hold_a) |=> ((event_a & $past(hold_a)) == $past(hold_a)))
    else $error("bank a flag dropped without a clear");

  a_sticky_bank_b: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (|hold_b) |=> ((event_b & $past(hold_b)) == $past(hold_b)))
    else $error("bank b flag dropped without a clear");

  a_clear_bank_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (|wipe_a) |=> ((event_a & $past(wipe_a)) == 8'h00))
    else $error("bank a clear left a flag set");

  a_clear_bank_b: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (|wipe_b) |=> ((event_b & $past(wipe_b)) == 8'h00))
    else $error("bank b clear left a flag set");

  a_unmask_a_write: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    reg_wr_i && hit_a |=> (unmask_a_q == $past(reg_wdata_i)))
    else $error("bank a write did not land");

  a_unmask_b_write: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    reg_wr_i && hit_b |=> (unmask_b_q == ($past(reg_wdata_i) & `BANK_B_USED_MASK)))
    else $error("bank b write did not land or kept reserved bits");

  a_rdata_hold: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
endmodule

// File: test/host_model.sv
/*
  Host side of the register port: single byte writes and reads, one at a time.
  Assumes the block samples its strobes on the rising edge of clk_i.
*/
`timescale 1ns/10ps
module host_model (
  input  wire logic        clk_i,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [15:0]      reg_addr_o,
  output logic [7:0]       reg_wdata_o,
  input  wire logic [7:0]  reg_rdata_i
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 16'h0000;
    reg_wdata_o = 8'h00;
  end

  // Released lines show the inverse, so a stale value can never pass
  task automatic write_reg(input logic [15:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    reg_wr_o    <= 1'b1;
    reg_addr_o  <= addr;
    reg_wdata_o <= data;
    @(posedge clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~addr;
    reg_wdata_o <= ~data;
  endtask

  // Read data stand from the read edge on, so they are taken one edge later
  task automatic read_reg(input logic [15:0] addr, output logic [7:0] data);
    @(posedge clk_i);
    reg_rd_o   <= 1'b1;
    reg_addr_o <= addr;
    @(posedge clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~addr;
    @(posedge clk_i);
    data = reg_rdata_i;
  endtask
endmodule

// File: test/interrupt_unmask_control_tb.sv
/*
  Self-checking bench for the event unmask block.
  Assumes the host model drives the register port; the bench drives raw levels.
*/
`timescale 1ns/10ps
`include "interrupt_unmask_map.svh"
module interrupt_unmask_control_tb;
  logic        clk_i           = 1'b0;
  logic        nrst_i          = 1'b0;
  logic        irq_en          = 1'b0;
  logic [15:0] raw_ab          = 16'h0000;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  event_a;
  logic [7:0]  event_b;
  logic        irq;
  int          n_mismatch      = 0;
  int          samples_checked = 0;
  int          cycles          = 0;

  always #5 clk_i = ~clk_i;

  host_model u_host (
    .clk_i       (clk_i),
    .reg_wr_o    (reg_wr),
    .reg_rd_o    (reg_rd),
    .reg_addr_o  (reg_addr),
    .reg_wdata_o (reg_wdata),
    .reg_rdata_i (reg_rdata)
  );

  interrupt_unmask_control u_dut (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .reg_wr_i    (reg_wr),
    .reg_rd_i    (reg_rd),
    .reg_addr_i  (reg_addr),
    .reg_wdata_i (reg_wdata),
    .reg_rdata_o (reg_rdata),
    .raw_a_i     (raw_ab[7:0]),
    .raw_b_i     (raw_ab[15:8]),
    .irq_en_i    (irq_en),
    .event_a_o   (event_a),
    .event_b_o   (event_b),
    .irq_o       (irq)
  );

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_reg(input logic [15:0] addr, input logic [7:0] exp);
    interrupt_unmask_pkg::reg_byte_t d;
    u_host.read_reg(addr, d);
    check({8'h00, d}, {8'h00, exp});
  endtask

  task automatic wr2(input logic [15:0] off_a, input logic [15:0] off_b, input logic [15:0] v);
    u_host.write_reg(off_a, v[7:0]);
    u_host.write_reg(off_b, v[15:8]);
  endtask

  task automatic drive(input logic [15:0] raw, input logic en);
    @(posedge clk_i);
    raw_ab <= raw;
    irq_en <= en;
  endtask

  // Eight cycles cover synchroniser, edge detect, flag and interrupt latency
  task automatic watch(input logic [15:0] exp_ev, input logic [15:0] exp_irq);
    logic [15:0] pulses;
    pulses = 16'h0000;
    repeat (8) begin
      @(posedge clk_i);
      #1;
      if (irq === 1'b1) pulses++;
    end
    check({event_b, event_a}, exp_ev);
    check(pulses, exp_irq);
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    logic [15:0] m;
    do_reset();
    check_reg(`UNMASK_BANK_A_OFF, 8'h02);
    check_reg(`UNMASK_BANK_B_OFF, 8'h00);
    u_host.write_reg(`UNMASK_BANK_B_OFF, 8'hff);
    check_reg(`UNMASK_BANK_B_OFF, 8'h37);
    u_host.write_reg(`UNMASK_BANK_A_OFF, 8'ha5);
    check_reg(`UNMASK_BANK_A_OFF, 8'ha5);
    check_reg(16'h2012, 8'h00);
    check_reg(`CLEAR_BANK_A_OFF, 8'h00);
    $display("test registers done");
    // Bank b positions 11, 14 and 15 are reserved and skipped here
    for (int p = 0; p < 14; p++) begin
      if (p == 11) continue;
      m = 16'h0001 << p;
      wr2(`UNMASK_BANK_A_OFF, `UNMASK_BANK_B_OFF, 16'h0000);
      drive(m, 1'b1);
      watch(16'h0000, 16'h0000);
      wr2(`UNMASK_BANK_A_OFF, `UNMASK_BANK_B_OFF, m);
      watch(16'h0000, 16'h0000);
      drive(16'h0000, 1'b1);
      drive(m, 1'b1);
      watch(m, 16'h0001);
      wr2(`CLEAR_BANK_A_OFF, `CLEAR_BANK_B_OFF, 16'h0000);
      watch(m, 16'h0000);
      wr2(`CLEAR_BANK_A_OFF, `CLEAR_BANK_B_OFF, m);
      watch(16'h0000, 16'h0000);
      drive(16'h0000, 1'b1);
    end
    $display("test per-flag gating done");
    wr2(`UNMASK_BANK_A_OFF, `UNMASK_BANK_B_OFF, 16'hffff);
    drive(16'hffff, 1'b0);
    watch(16'h37ff, 16'h0000);
    drive(16'h0000, 1'b1);
    drive(16'hffff, 1'b1);
    watch(16'h37ff, 16'h0000);
    wr2(`CLEAR_BANK_A_OFF, `CLEAR_BANK_B_OFF, 16'hffff);
    watch(16'h0000, 16'h0000);
    drive(16'h0000, 1'b1);
    $display("test all flags done");
    do_reset();
    check_reg(`UNMASK_BANK_B_OFF, 8'h00);
    drive(16'h0003, 1'b1);
    watch(16'h0002, 16'h0001);
    $display("test second reset done");
    give_verdict();
  end
endmodule
